// ---- rtl/carry_cpl_rev.sv ----
// Carry flag update for carry-complement with revision-dependent fault
//
// Contract
// - Complement-carry inverts the carry flag in normal operation.
// - Fault revs keep carry 1 if complement directly follows JB, JNB or JBC.
// - In fault revisions a carry of 0 still becomes 1 after that sequence.
// - The fault applies whether the preceding bit branch was taken or not.
// - Only a bit branch executed just before the complement triggers it.
// - The corrected revision always inverts carry on complement.
module carry_cpl_rev #(
   parameter logic FAULT_REV = carry_cpl_pkg::REV_FAULT
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Execute stage
   input  wire logic       exec_valid,
   input  wire logic [7:0] exec_opcode,
   input  wire logic       branch_taken,
   // Other carry writers
   input  wire logic       carry_we,
   input  wire logic       carry_wdata,
   // Results
   output logic            carry_r,
   output logic            branch_taken_r,
   output logic            fault_hit_r
);

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic       prev_bitbr_r;
   logic       is_cpl;
   logic       is_bitbr;
   logic       trig;
   logic       carry_nxt;

   assign is_cpl   = exec_valid && (exec_opcode == carry_cpl_pkg::OP_CPL_C);
   assign is_bitbr = exec_valid &&
                     ((exec_opcode == carry_cpl_pkg::OP_JB)  ||
                      (exec_opcode == carry_cpl_pkg::OP_JNB) ||
                      (exec_opcode == carry_cpl_pkg::OP_JBC));
   assign trig = (FAULT_REV == carry_cpl_pkg::REV_FAULT) && is_cpl &&
                 prev_bitbr_r && carry_r;

   // ---------------------------------------------------------------
   // Previous instruction tracking
   // ---------------------------------------------------------------
   // history of last executed op
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_bitbr_r <= 1'b0;
      end else if (exec_valid) begin
         prev_bitbr_r <= is_bitbr;
      end
   end

   // ---------------------------------------------------------------
   // Carry update
   // ---------------------------------------------------------------
   always_comb begin
      carry_nxt = carry_r;
      if (is_cpl) begin
         carry_nxt = trig ? 1'b1 : ~carry_r;
      end else if (carry_we) begin
         carry_nxt = carry_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         carry_r <= carry_cpl_pkg::CARRY_RESET;
      end else begin
         carry_r <= carry_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         branch_taken_r <= 1'b0;
      end else begin
         branch_taken_r <= is_bitbr && branch_taken;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fault_hit_r <= 1'b0;
      end else begin
         fault_hit_r <= trig;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_bitbr;
      exec_valid && (exec_opcode == carry_cpl_pkg::OP_JB ||
                     exec_opcode == carry_cpl_pkg::OP_JNB ||
                     exec_opcode == carry_cpl_pkg::OP_JBC);
   endsequence
   sequence s_cpl;
      exec_valid && exec_opcode == carry_cpl_pkg::OP_CPL_C;
   endsequence
   sequence s_nop;
      exec_valid && exec_opcode == carry_cpl_pkg::OP_NOP;
   endsequence
   sequence s_bubble;
      !exec_valid;
   endsequence
   sequence s_cpl_set;
      s_cpl and carry_r;
   endsequence

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------

   property p_invert_plain;
      @(posedge clk) disable iff (!resetn)
      (s_cpl and !prev_bitbr_r) |=> (carry_r != $past(carry_r));
   endproperty
   a_invert_plain: assert property (p_invert_plain)
      else $error("carry not inverted");

   property p_stuck;
      @(posedge clk) disable iff (!resetn)
      (FAULT_REV && carry_r) ##0 s_bitbr ##1 (s_cpl and carry_r)
         |=> carry_r;
   endproperty
   a_stuck: assert property (p_stuck)
      else $error("fault carry cleared");

   property p_zero_sets;
      @(posedge clk) disable iff (!resetn)
      s_bitbr ##1 (s_cpl and !carry_r) |=> carry_r;
   endproperty
   a_zero_sets: assert property (p_zero_sets)
      else $error("carry zero not set");

   property p_taken_either;
      @(posedge clk) disable iff (!resetn)
      (s_bitbr and !branch_taken) ##1 (s_cpl and carry_r)
         |-> fault_hit_r == 1'b0 ##1 fault_hit_r == FAULT_REV;
   endproperty
   a_taken_either: assert property (p_taken_either)
      else $error("not-taken branch differs");

   property p_nop_gap;
      @(posedge clk) disable iff (!resetn)
      s_bitbr ##1 s_nop ##1 s_cpl_set
         |=> !carry_r;
   endproperty
   a_nop_gap: assert property (p_nop_gap)
      else $error("gap did not restore inversion");

   property p_corrected;
      @(posedge clk) disable iff (!resetn)
      (!FAULT_REV && is_cpl) |=> carry_r == !$past(carry_r);
   endproperty
   a_corrected: assert property (p_corrected)
      else $error("corrected rev failed");

   property p_branch_kept;
      @(posedge clk) disable iff (!resetn)
      s_bitbr |=> branch_taken_r == $past(branch_taken);
   endproperty
   a_branch_kept: assert property (p_branch_kept)
      else $error("branch outcome altered");

   property p_fault_only_cpl;
      @(posedge clk) disable iff (!resetn)
      fault_hit_r |-> $past(is_cpl) && $past(carry_r) && carry_r;
   endproperty
   a_fault_only_cpl: assert property (p_fault_only_cpl)
      else $error("fault flagged without cause");

   property p_taken_fault;
      @(posedge clk) disable iff (!resetn)
      (s_bitbr and branch_taken) ##1 s_cpl_set
         |=> fault_hit_r == FAULT_REV;
   endproperty
   a_taken_fault: assert property (p_taken_fault)
      else $error("taken branch differs");

   property p_bubble_keeps;
      @(posedge clk) disable iff (!resetn)
      s_bitbr ##1 s_bubble ##1 s_cpl_set |=> carry_r == FAULT_REV;
   endproperty
   a_bubble_keeps: assert property (p_bubble_keeps)
      else $error("bubble broke branch history");

   property p_fault_pulse;
      @(posedge clk) disable iff (!resetn)
      fault_hit_r |=> !fault_hit_r;
   endproperty
   a_fault_pulse: assert property (p_fault_pulse)
      else $error("fault flag held too long");

   property p_cpl_beats_write;
      @(posedge clk) disable iff (!resetn)
      (s_cpl and carry_we) |=> carry_r != $past(carry_r) || fault_hit_r;
   endproperty
   a_cpl_beats_write: assert property (p_cpl_beats_write)
      else $error("carry write overrode complement");

   property p_other_write;
      @(posedge clk) disable iff (!resetn)
      (!is_cpl && carry_we) |=> carry_r == $past(carry_wdata);
   endproperty
   a_other_write: assert property (p_other_write)
      else $error("carry write lost");

   property p_carry_hold;
      @(posedge clk) disable iff (!resetn)
      (!is_cpl && !carry_we) |=> $stable(carry_r);
   endproperty
   a_carry_hold: assert property (p_carry_hold)
      else $error("carry changed with no writer");

   property p_branch_idle;
      @(posedge clk) disable iff (!resetn)
      !is_bitbr |=> !branch_taken_r;
   endproperty
   a_branch_idle: assert property (p_branch_idle)
      else $error("branch outcome without branch");

endmodule

// ---- pkg/carry_cpl_pkg.sv ----
// Constants for the carry-complement revision model
package carry_cpl_pkg;

   // ---------------------------------------------------------------
   // Opcodes of interest
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_CPL_C = 8'hb3;
   localparam logic [7:0] OP_JBC   = 8'h10;
   localparam logic [7:0] OP_JB    = 8'h20;
   localparam logic [7:0] OP_JNB   = 8'h30;
   localparam logic [7:0] OP_NOP   = 8'h00;

   // ---------------------------------------------------------------
   // Revision selection
   // ---------------------------------------------------------------
   localparam logic       REV_FAULT     = 1'b1;
   localparam logic       REV_CORRECTED = 1'b0;
   localparam logic       CARRY_RESET   = 1'b0;

endpackage

// ---- testbench/exec_feeder.sv ----
// Execute-stage feeder standing in for the core pipeline
module exec_feeder (
   // Clock
   input  wire logic       clk,
   // Execute stage
   output logic            exec_valid,
   output logic [7:0]      exec_opcode,
   output logic            branch_taken,
   output logic            carry_we,
   output logic            carry_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial exec_valid = 1'b0;
   initial exec_opcode = 8'h5a;
   initial {branch_taken, carry_we, carry_wdata} = 3'h0;
   // Bubble shows a scrambled opcode
   task automatic issue(input logic v, input logic [7:0] op,
                        input logic t, w, d);
      @(posedge clk);
      exec_valid   <= v;
      exec_opcode  <= v ? op : ~exec_opcode;
      branch_taken <= t;
      carry_we     <= w;
      carry_wdata  <= d;
   endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for both carry revisions
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, resetn, ev, tk, we, wd;
   logic [7:0] op;
   logic       c_f, c_c, b_f, b_c, h_f;
   logic [7:0] br [3];
   int         bad_count, samples_checked;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   exec_feeder feed (.clk(clk), .exec_valid(ev), .exec_opcode(op),
      .branch_taken(tk), .carry_we(we), .carry_wdata(wd));
   carry_cpl_rev #(.FAULT_REV(carry_cpl_pkg::REV_FAULT)) dut (
      .clk(clk), .resetn(resetn), .exec_valid(ev), .exec_opcode(op),
      .branch_taken(tk), .carry_we(we), .carry_wdata(wd),
      .carry_r(c_f), .branch_taken_r(b_f), .fault_hit_r(h_f));
   carry_cpl_rev #(.FAULT_REV(carry_cpl_pkg::REV_CORRECTED)) fix (
      .clk(clk), .resetn(resetn), .exec_valid(ev), .exec_opcode(op),
      .branch_taken(tk), .carry_we(we), .carry_wdata(wd),
      .carry_r(c_c), .branch_taken_r(b_c), .fault_hit_r());
   task automatic chk(input logic s, e, input string n);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %b seen %b", n, e, s);
      end
   endtask
   // Set carry, run p then CPL; carry write on CPL must be ignored
   task automatic seq(input logic [7:0] p, input logic t, c0, isb);
      logic f;
      f = c0 & isb;
      feed.issue(1'b1, carry_cpl_pkg::OP_NOP, 1'b0, 1'b1, c0);
      feed.issue(1'b1, p, t, 1'b0, 1'b0);
      feed.issue(1'b1, carry_cpl_pkg::OP_CPL_C, 1'b0, 1'b1, c0);
      #1;
      chk(b_f, t & isb, "branch_fault_rev");
      chk(b_c, t & isb, "branch_fixed_rev");
      feed.issue(1'b0, carry_cpl_pkg::OP_CPL_C, 1'b0, 1'b0, 1'b0);
      #1;
      chk(c_f, f | ~c0, "carry_fault_rev");
      chk(h_f, f, "fault_hit");
      chk(c_c, ~c0, "carry_fixed_rev");
   endtask
   task automatic t_fault();
      foreach (br[i])
         for (int t = 0; t < 2; t++) seq(br[i], t[0], 1'b1, 1'b1);
      $display("test fault after bit branch done");
   endtask
   task automatic t_zero();
      foreach (br[i]) seq(br[i], 1'b1, 1'b0, 1'b1);
      $display("test carry zero after bit branch done");
   endtask
   task automatic t_nop();
      seq(carry_cpl_pkg::OP_NOP, 1'b0, 1'b1, 1'b0);
      seq(carry_cpl_pkg::OP_NOP, 1'b1, 1'b0, 1'b0);
      $display("test intervening instruction done");
   endtask
   // Bit branch, then a NOP or a bubble, then CPL with carry set
   task automatic gap(input logic [7:0] p, input logic v);
      feed.issue(1'b1, carry_cpl_pkg::OP_NOP, 1'b0, 1'b1, 1'b1);
      feed.issue(1'b1, p, 1'b1, 1'b0, 1'b0);
      feed.issue(v, carry_cpl_pkg::OP_NOP, 1'b0, 1'b0, 1'b0);
      feed.issue(1'b1, carry_cpl_pkg::OP_CPL_C, 1'b0, 1'b0, 1'b0);
      feed.issue(1'b0, carry_cpl_pkg::OP_CPL_C, 1'b0, 1'b0, 1'b0);
      #1;
      chk(c_f, ~v, "carry_gap_fault_rev");
      chk(h_f, ~v, "fault_hit_gap");
      chk(c_c, 1'b0, "carry_gap_fixed_rev");
   endtask
   task automatic t_gap();
      foreach (br[i]) for (int v = 0; v < 2; v++) gap(br[i], v[0]);
      $display("test gap after bit branch done");
   endtask
   // Mid-run reset clears flags and the first CPL after it inverts
   task automatic t_reset();
      feed.issue(1'b1, carry_cpl_pkg::OP_NOP, 1'b0, 1'b1, 1'b1);
      feed.issue(1'b1, carry_cpl_pkg::OP_JB, 1'b1, 1'b0, 1'b0);
      feed.issue(1'b0, carry_cpl_pkg::OP_NOP, 1'b0, 1'b0, 1'b0);
      resetn <= 1'b0;
      #1;
      chk(b_f, 1'b1, "branch_before_reset");
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk(c_f, carry_cpl_pkg::CARRY_RESET, "carry_after_reset");
      chk(b_f, 1'b0, "branch_after_reset");
      chk(h_f, 1'b0, "fault_hit_after_reset");
      feed.issue(1'b1, carry_cpl_pkg::OP_CPL_C, 1'b0, 1'b0, 1'b0);
      feed.issue(1'b0, carry_cpl_pkg::OP_CPL_C, 1'b0, 1'b0, 1'b0);
      #1;
      chk(c_f, ~carry_cpl_pkg::CARRY_RESET, "carry_first_cpl");
      $display("test mid-run reset done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      br = '{carry_cpl_pkg::OP_JB, carry_cpl_pkg::OP_JNB,
             carry_cpl_pkg::OP_JBC};
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_fault();
      t_zero();
      t_nop();
      t_gap();
      t_reset();
      conclude();
   end
endmodule
